// ### cwc_defs.vh
// Constants for the core interrupt and wake control block.
`ifndef CWC_DEFS_VH
`define CWC_DEFS_VH

// --------------------------------------------------------------------
// Clock and timing
// --------------------------------------------------------------------
`define CWC_CLK_MHZ 50
`define CWC_SAVE_CYCLES 3'h4
`define CWC_RESTORE_CYCLES 3'h4

// --------------------------------------------------------------------
// Source layout
// --------------------------------------------------------------------
`define CWC_EXT_LINES 25
`define CWC_SRC_W 26
`define CWC_WAKE_MASK 26'h000003f
`define CWC_TICK_W 24

// --------------------------------------------------------------------
// Register byte offsets
// --------------------------------------------------------------------
`define CWC_REG_STATUS 8'h00
`define CWC_REG_MASK 8'h04
`define CWC_REG_SLEEP 8'h08
`define CWC_REG_TICK_CTRL 8'h0c
`define CWC_REG_TICK_RELOAD 8'h10
`define CWC_REG_TICK_VALUE 8'h14
`define CWC_REG_EDGE_A 8'h18
`define CWC_REG_EDGE_C 8'h1c
`define CWC_REG_EDGE_D 8'h20
`define CWC_REG_EDGE_E 8'h24
`define CWC_REG_ANALOG 8'h28
`define CWC_REG_DBG_CTRL 8'h2c
`define CWC_REG_MUL_A 8'h30
`define CWC_REG_MUL_B 8'h34
`define CWC_REG_MUL_LO 8'h38
`define CWC_REG_MUL_HI 8'h3c
`define CWC_REG_ACTIVE 8'h40

// --------------------------------------------------------------------
// Field positions and responses
// --------------------------------------------------------------------
`define CWC_SLEEP_DEEP_BIT 0
`define CWC_SLEEP_ENTER_BIT 1
`define CWC_TICK_EN_BIT 0
`define CWC_TICK_INT_BIT 1
`define CWC_DBG_OFF_BIT 0
`define CWC_RESP_OKAY 2'h0
`define CWC_RESP_SLVERR 2'h2

`endif

// ### cwc_tick.v
// System tick down-counter with 24-bit reload.
`timescale 1ns/1ps
`include "cwc_defs.vh"

module cwc_tick (
    input wire aclk,
    input wire aresetn,
    input wire ce,
    input wire enable,
    input wire [`CWC_TICK_W-1:0] reload,
    input wire clear_value,
    output reg [`CWC_TICK_W-1:0] value,
    output reg wrap
);

    // ----------------------------------------------------------------
    // Counter
    // ----------------------------------------------------------------
    // A zero count reloads, so a nonzero reload of N gives a period of N+1 cycles; a reload of 0 never wraps.
    always @(posedge aclk) begin
        if (!aresetn) begin
            value <= 24'h000000;
            wrap <= 1'b0;
        end else if (ce) begin
            wrap <= 1'b0;
            if (clear_value) begin
                value <= 24'h000000;
            end else if (enable) begin
                if (value == 24'h000000) begin
                    value <= reload;
                end else begin
                    value <= value - 24'h000001;
                    wrap <= (value == 24'h000001);
                end
            end
        end
    end

endmodule // cwc_tick

// ### cwc_port_edge.v
// Edge detector for one 8-pin port with per-pin edge selection.
`timescale 1ns/1ps

module cwc_port_edge (
    input wire aclk,
    input wire aresetn,
    input wire ce,
    input wire [7:0] pins,
    input wire [7:0] rise_en,
    input wire [7:0] fall_en,
    output reg event_out
);

    reg [7:0] prev;
    reg primed;

    // ----------------------------------------------------------------
    // Edge detection
    // ----------------------------------------------------------------
    // The first sample after reset only primes the history, so pins
    // that rest high do not raise a false rising edge.
    always @(posedge aclk) begin
        if (!aresetn) begin
            prev <= 8'h00;
            primed <= 1'b0;
            event_out <= 1'b0;
        end else if (ce) begin
            prev <= pins;
            primed <= 1'b1;
            event_out <= primed & |((pins & ~prev & rise_en) | (~pins & prev & fall_en));
        end
    end

endmodule // cwc_port_edge

// ### cwc_top.v
// Interrupt, wake-up and low-power control around the processor core.
//
// Behaviour
// - Controller takes 25 external interrupt lines plus internal exceptions.
// - Pending interrupt at handler end chains directly, no restore or save.
// - Port, calendar or watchdog interrupts wake the device.
// - Software picks light or deep sleep.
// - Deep sleep gates the core clock.
// - 24-bit system tick down-counter raises a periodic exception.
// - Little-endian: lowest address holds the least significant byte.
// - Four breakpoint and two watchpoint comparators, set by the debugger.
// - Debug access can be disabled; then the debugger reaches nothing.
// - Runs from the processor clock up to 50MHz.
// - Each 8-pin port interrupts on configurable edges.
// - 32 by 32 multiply completes in one cycle.
// - Six low-voltage port pins double as converter inputs.
`timescale 1ns/1ps
`include "cwc_defs.vh"

module cwc_top (
    input wire aclk,
    input wire aresetn,
    input wire ce,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire [`CWC_EXT_LINES-1:0] irq_lines,
    input wire rtc_irq,
    input wire watch_timer_irq,
    input wire [7:0] port_a_pins,
    input wire [7:0] port_c_pins,
    input wire [7:0] port_d_pins,
    input wire [7:0] port_e_pins,
    output reg [5:0] converter_input_en,
    input wire handler_done,
    output wire handler_active,
    output reg [4:0] handler_num,
    output reg tail_chain,
    output wire ctx_save,
    output wire ctx_restore,
    output wire core_clk_en,
    output wire core_halt,
    input wire dbg_wr,
    input wire [2:0] dbg_sel,
    input wire [31:0] dbg_addr,
    input wire [31:0] fetch_addr,
    input wire fetch_valid,
    input wire [31:0] data_addr,
    input wire data_valid,
    output reg break_hit,
    output reg watch_hit,
    output wire dbg_enabled,
    output wire irq_out
);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    localparam ST_IDLE = 2'h0;
    localparam ST_SAVE = 2'h1;
    localparam ST_ACTIVE = 2'h2;
    localparam ST_RESTORE = 2'h3;
    localparam SL_RUN = 2'h0;
    localparam SL_LIGHT = 2'h1;
    localparam SL_DEEP = 2'h2;

    reg [7:0] aw_addr;
    reg aw_held;
    reg [31:0] w_data;
    reg [3:0] w_strb;
    reg w_held;
    reg [`CWC_SRC_W-1:0] pend;
    reg [`CWC_SRC_W-1:0] mask;
    reg deep_sel;
    reg [1:0] sleep_state;
    reg tick_en;
    reg tick_int;
    reg [23:0] tick_reload;
    reg [15:0] edge_cfg [0:3];
    reg dbg_off;
    reg [31:0] mul_a;
    reg [31:0] mul_b;
    reg [1:0] state;
    reg [2:0] count;
    reg [31:0] bp_addr [0:3];
    reg [31:0] wp_addr [0:1];
    reg [31:0] next_rdata;
    reg [1:0] next_rresp;
    wire [4:0] next_num;
    reg [3:0] bp_match;
    reg [1:0] wp_match;
    integer i;
    wire wr_go;
    wire [3:0] port_evt;
    wire [23:0] tick_value;
    wire tick_wrap;
    wire [63:0] product;
    wire [`CWC_SRC_W-1:0] events;
    wire [`CWC_SRC_W-1:0] ready_src;
    wire [`CWC_SRC_W-1:0] w1c;
    wire [`CWC_SRC_W-1:0] take;
    wire [7:0] port_c_digital;
    wire wake;

    // ----------------------------------------------------------------
    // Bus handshakes
    // ----------------------------------------------------------------
    // Address and data are parked independently; the response waits for both.
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign wr_go = aw_held && w_held && !s_axi_bvalid && ce;

    // Byte lane k carries the byte at address offset k.
    function [31:0] merge;
        input [31:0] old;
        input [31:0] data;
        input [3:0] strb;
        integer k;
        begin
            merge = old;
            for (k = 0; k < 4; k = k + 1) begin
                if (strb[k]) begin
                    merge[8*k +: 8] = data[8*k +: 8];
                end
            end
        end
    endfunction

    function [4:0] lowest;
        input [`CWC_SRC_W-1:0] v;
        integer k;
        begin
            lowest = 5'h00;
            for (k = `CWC_SRC_W - 1; k >= 0; k = k - 1) begin
                if (v[k]) begin
                    lowest = k[4:0];
                end
            end
        end
    endfunction

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_addr <= 8'h00;
            aw_held <= 1'b0;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `CWC_RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `CWC_RESP_OKAY;
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr <= s_axi_awaddr;
                aw_held <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
                w_held <= 1'b1;
            end
            if (wr_go) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (aw_addr[1:0] != 2'h0 || aw_addr > `CWC_REG_ACTIVE) ?
                    `CWC_RESP_SLVERR : `CWC_RESP_OKAY;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= next_rdata;
                s_axi_rresp <= next_rresp;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Read mux
    // ----------------------------------------------------------------
    assign product = mul_a * mul_b;

    always @* begin
        next_rresp = `CWC_RESP_OKAY;
        case (s_axi_araddr)
            `CWC_REG_STATUS: next_rdata = {6'h00, pend};
            `CWC_REG_MASK: next_rdata = {6'h00, mask};
            `CWC_REG_SLEEP: next_rdata = {28'h0000000, sleep_state, 1'b0, deep_sel};
            `CWC_REG_TICK_CTRL: next_rdata = {30'h00000000, tick_int, tick_en};
            `CWC_REG_TICK_RELOAD: next_rdata = {8'h00, tick_reload};
            `CWC_REG_TICK_VALUE: next_rdata = {8'h00, tick_value};
            `CWC_REG_EDGE_A: next_rdata = {16'h0000, edge_cfg[0]};
            `CWC_REG_EDGE_C: next_rdata = {16'h0000, edge_cfg[1]};
            `CWC_REG_EDGE_D: next_rdata = {16'h0000, edge_cfg[2]};
            `CWC_REG_EDGE_E: next_rdata = {16'h0000, edge_cfg[3]};
            `CWC_REG_ANALOG: next_rdata = {26'h0000000, converter_input_en};
            `CWC_REG_DBG_CTRL: next_rdata = {31'h00000000, dbg_off};
            `CWC_REG_MUL_A: next_rdata = mul_a;
            `CWC_REG_MUL_B: next_rdata = mul_b;
            `CWC_REG_MUL_LO: next_rdata = product[31:0];
            `CWC_REG_MUL_HI: next_rdata = product[63:32];
            `CWC_REG_ACTIVE: next_rdata = {24'h000000, state, handler_active, handler_num};
            default: begin
                next_rdata = 32'h00000000;
                next_rresp = `CWC_RESP_SLVERR;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // Control registers
    // ----------------------------------------------------------------
    wire [31:0] m_mask = merge({6'h00, mask}, w_data, w_strb);
    wire [31:0] m_reload = merge({8'h00, tick_reload}, w_data, w_strb);
    wire [31:0] m_edge_a = merge({16'h0000, edge_cfg[0]}, w_data, w_strb);
    wire [31:0] m_edge_c = merge({16'h0000, edge_cfg[1]}, w_data, w_strb);
    wire [31:0] m_edge_d = merge({16'h0000, edge_cfg[2]}, w_data, w_strb);
    wire [31:0] m_edge_e = merge({16'h0000, edge_cfg[3]}, w_data, w_strb);
    wire [31:0] m_stat = merge(32'h00000000, w_data, w_strb);

    always @(posedge aclk) begin
        if (!aresetn) begin
            mask <= 26'h0000000;
            deep_sel <= 1'b0;
            tick_en <= 1'b0;
            tick_int <= 1'b0;
            tick_reload <= 24'h000000;
            dbg_off <= 1'b0;
            mul_a <= 32'h00000000;
            mul_b <= 32'h00000000;
            converter_input_en <= 6'h00;
            for (i = 0; i < 4; i = i + 1) begin
                edge_cfg[i] <= 16'h0000;
            end
        end else if (ce && wr_go) begin
            if (aw_addr == `CWC_REG_MASK) mask <= m_mask[25:0];
            if (aw_addr == `CWC_REG_SLEEP && w_strb[0]) deep_sel <= w_data[`CWC_SLEEP_DEEP_BIT];
            if (aw_addr == `CWC_REG_TICK_CTRL && w_strb[0]) begin
                tick_en <= w_data[`CWC_TICK_EN_BIT];
                tick_int <= w_data[`CWC_TICK_INT_BIT];
            end
            if (aw_addr == `CWC_REG_TICK_RELOAD) tick_reload <= m_reload[23:0];
            if (aw_addr == `CWC_REG_EDGE_A) edge_cfg[0] <= m_edge_a[15:0];
            if (aw_addr == `CWC_REG_EDGE_C) edge_cfg[1] <= m_edge_c[15:0];
            if (aw_addr == `CWC_REG_EDGE_D) edge_cfg[2] <= m_edge_d[15:0];
            if (aw_addr == `CWC_REG_EDGE_E) edge_cfg[3] <= m_edge_e[15:0];
            if (aw_addr == `CWC_REG_ANALOG && w_strb[0]) converter_input_en <= w_data[5:0];
            // Disabling debug is one-way until reset, so firmware cannot be reopened.
            if (aw_addr == `CWC_REG_DBG_CTRL && w_strb[0] && w_data[`CWC_DBG_OFF_BIT]) dbg_off <= 1'b1;
            if (aw_addr == `CWC_REG_MUL_A) mul_a <= merge(mul_a, w_data, w_strb);
            if (aw_addr == `CWC_REG_MUL_B) mul_b <= merge(mul_b, w_data, w_strb);
        end
    end

    // ----------------------------------------------------------------
    // Event sources
    // ----------------------------------------------------------------
    cwc_tick u_tick (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .enable(tick_en),
        .reload(tick_reload),
        .clear_value(wr_go && aw_addr == `CWC_REG_TICK_VALUE),
        .value(tick_value),
        .wrap(tick_wrap)
    );

    // Pins routed to the converter are left out of digital edge detection.
    assign port_c_digital = port_c_pins & {2'h3, ~converter_input_en};

    cwc_port_edge u_edge_a (.aclk(aclk), .aresetn(aresetn), .ce(ce), .pins(port_a_pins),
        .rise_en(edge_cfg[0][7:0]), .fall_en(edge_cfg[0][15:8]), .event_out(port_evt[0]));
    cwc_port_edge u_edge_c (.aclk(aclk), .aresetn(aresetn), .ce(ce), .pins(port_c_digital),
        .rise_en(edge_cfg[1][7:0]), .fall_en(edge_cfg[1][15:8]), .event_out(port_evt[1]));
    cwc_port_edge u_edge_d (.aclk(aclk), .aresetn(aresetn), .ce(ce), .pins(port_d_pins),
        .rise_en(edge_cfg[2][7:0]), .fall_en(edge_cfg[2][15:8]), .event_out(port_evt[2]));
    cwc_port_edge u_edge_e (.aclk(aclk), .aresetn(aresetn), .ce(ce), .pins(port_e_pins),
        .rise_en(edge_cfg[3][7:0]), .fall_en(edge_cfg[3][15:8]), .event_out(port_evt[3]));

    // Ports, calendar timer and watchdog share the low lines with their peripherals.
    assign events = {tick_wrap & tick_int,
                     irq_lines[24:6],
                     irq_lines[5] | watch_timer_irq,
                     irq_lines[4] | rtc_irq,
                     irq_lines[3:0] | port_evt};

    // ----------------------------------------------------------------
    // Pending status and vectoring
    // ----------------------------------------------------------------
    assign w1c = (wr_go && aw_addr == `CWC_REG_STATUS) ? m_stat[25:0] : 26'h0000000;
    assign ready_src = pend & mask;
    assign irq_out = |ready_src;
    assign next_num = lowest(ready_src);
    assign take = ((state == ST_IDLE && sleep_state == SL_RUN && irq_out) ||
                   (state == ST_ACTIVE && handler_done && irq_out)) ? (26'h0000001 << next_num) : 26'h0000000;
    assign handler_active = (state == ST_ACTIVE);
    assign ctx_save = (state == ST_SAVE);
    assign ctx_restore = (state == ST_RESTORE);

    // A new event beats a clear in the same cycle, and waking never clears a bit.
    always @(posedge aclk) begin
        if (!aresetn) begin
            pend <= 26'h0000000;
        end else if (ce) begin
            pend <= (pend & ~w1c & ~take) | events;
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            state <= ST_IDLE;
            count <= 3'h0;
            handler_num <= 5'h00;
            tail_chain <= 1'b0;
        end else if (ce) begin
            tail_chain <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (|take) begin
                        handler_num <= next_num;
                        count <= `CWC_SAVE_CYCLES;
                        state <= ST_SAVE;
                    end
                end
                ST_SAVE: begin
                    count <= count - 3'h1;
                    if (count == 3'h1) state <= ST_ACTIVE;
                end
                ST_ACTIVE: begin
                    if (handler_done && irq_out) begin
                        handler_num <= next_num;
                        tail_chain <= 1'b1;
                    end else if (handler_done) begin
                        count <= `CWC_RESTORE_CYCLES;
                        state <= ST_RESTORE;
                    end
                end
                ST_RESTORE: begin
                    count <= count - 3'h1;
                    if (count == 3'h1) state <= ST_IDLE;
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Low-power control
    // ----------------------------------------------------------------
    // Deep sleep listens only to the wake sources; light sleep to any enabled one.
    assign wake = |(pend & `CWC_WAKE_MASK) || (sleep_state == SL_LIGHT && irq_out);
    assign core_halt = (sleep_state != SL_RUN);
    assign core_clk_en = (sleep_state != SL_DEEP);

    always @(posedge aclk) begin
        if (!aresetn) begin
            sleep_state <= SL_RUN;
        end else if (ce) begin
            case (sleep_state)
                SL_RUN: begin
                    // The depth written with the enter bit applies to this entry.
                    if (wr_go && aw_addr == `CWC_REG_SLEEP && w_strb[0] && w_data[`CWC_SLEEP_ENTER_BIT] &&
                        state == ST_IDLE) begin
                        sleep_state <= w_data[`CWC_SLEEP_DEEP_BIT] ? SL_DEEP : SL_LIGHT;
                    end
                end
                SL_LIGHT: if (wake) sleep_state <= SL_RUN;
                SL_DEEP: if (wake) sleep_state <= SL_RUN;
                default: sleep_state <= SL_RUN;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Debug comparators
    // ----------------------------------------------------------------
    assign dbg_enabled = !dbg_off;

    always @* begin
        bp_match[0] = (bp_addr[0] == fetch_addr);
        bp_match[1] = (bp_addr[1] == fetch_addr);
        bp_match[2] = (bp_addr[2] == fetch_addr);
        bp_match[3] = (bp_addr[3] == fetch_addr);
        wp_match[0] = (wp_addr[0] == data_addr);
        wp_match[1] = (wp_addr[1] == data_addr);
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            break_hit <= 1'b0;
            watch_hit <= 1'b0;
            bp_addr[0] <= 32'h00000000;
            bp_addr[1] <= 32'h00000000;
            bp_addr[2] <= 32'h00000000;
            bp_addr[3] <= 32'h00000000;
            wp_addr[0] <= 32'h00000000;
            wp_addr[1] <= 32'h00000000;
        end else if (ce) begin
            if (dbg_wr && !dbg_off) begin
                if (dbg_sel[2] == 1'b0) bp_addr[dbg_sel[1:0]] <= dbg_addr;
                else if (dbg_sel[1] == 1'b0) wp_addr[dbg_sel[0]] <= dbg_addr;
            end
            break_hit <= !dbg_off && fetch_valid && |bp_match;
            watch_hit <= !dbg_off && data_valid && |wp_match;
        end
    end

    // Timing figures assume the processor clock of CWC_CLK_MHZ or slower.

endmodule // cwc_top

// ### cwc_sva.sv
// Checker on the ports of the interrupt and wake control block.
`timescale 1ns/1ps
module cwc_chk (
    input logic aclk,
    input logic aresetn,
    input logic handler_done,
    input logic handler_active,
    input logic tail_chain,
    input logic ctx_save,
    input logic ctx_restore,
    input logic core_clk_en,
    input logic core_halt,
    input logic rtc_irq,
    input logic fetch_valid,
    input logic data_valid,
    input logic break_hit,
    input logic dbg_enabled
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_save; $rose(ctx_save) |-> ctx_save[*4] ##1 handler_active; endproperty
    a_save: assert property (p_save) else $error("save length");
    property p_chain; tail_chain |-> handler_active && !ctx_save && !ctx_restore; endproperty
    a_chain: assert property (p_chain) else $error("chain not direct");
    property p_done; handler_done && handler_active |=> tail_chain || ctx_restore; endproperty
    a_done: assert property (p_done) else $error("no chain or restore");
    property p_deep; !core_clk_en |-> core_halt; endproperty
    a_deep: assert property (p_deep) else $error("clock gated while running");
    property p_wake; core_halt && rtc_irq |-> ##[1:4] !core_halt; endproperty
    a_wake: assert property (p_wake) else $error("no wake");
    property p_break; break_hit |-> $past(fetch_valid); endproperty
    a_break: assert property (p_break) else $error("stray breakpoint");
    property p_off; !dbg_enabled && fetch_valid |=> !break_hit; endproperty
    a_off: assert property (p_off) else $error("hit while disabled");
    property p_stick; !dbg_enabled |=> !dbg_enabled; endproperty
    a_stick: assert property (p_stick) else $error("debug re-enabled");
endmodule // cwc_chk

// ### cwc_core_model.sv
// Core stand-in that ends each handler lat+1 cycles after it starts.
`timescale 1ns/1ps
module cwc_core_model (
    input logic aclk,
    input logic aresetn,
    input logic handler_active,
    input logic [7:0] lat,
    output logic handler_done
);
    logic [7:0] cnt;
    wire run = handler_active && !handler_done;
    always @(posedge aclk) begin
        handler_done <= aresetn && run && cnt == lat;
        cnt <= (aresetn && run && cnt != lat) ? cnt + 8'h01 : 8'h00;
    end
endmodule // cwc_core_model

// ### tb_core_interrupt_wake_control.sv
// Self-checking bench for the interrupt and wake control block.
`timescale 1ns/1ps
`include "cwc_defs.vh"
module tb_core_interrupt_wake_control;
    logic aclk = '0, aresetn = '0, ce = 1'b1, s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
    logic s_axi_arvalid = '0, s_axi_rready = '0, rtc_irq = '0, watch_timer_irq = '0, dbg_wr = '0;
    logic fetch_valid = '0, data_valid = '0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, handler_done, handler_active, tail_chain, ctx_save, ctx_restore, core_clk_en;
    logic core_halt, break_hit, watch_hit, dbg_enabled, irq_out;
    logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0, port_a_pins = '0, port_c_pins = '0, port_d_pins = '0;
    logic [7:0] port_e_pins = '0, lat = 8'h02;
    logic [31:0] s_axi_wdata = '0, dbg_addr = '0, fetch_addr = '0, data_addr = '0, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [2:0] dbg_sel = '0;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [4:0] handler_num;
    logic [5:0] converter_input_en;
    logic [`CWC_EXT_LINES-1:0] irq_lines = '0;
    integer fails = 0, n_tests = 0, cyc = 0, k;
    logic [43:0] rows [0:12] = '{44'h0_04_ffffffff, 44'h1_04_03ffffff, 44'h0_10_ffffffff, 44'h1_10_00ffffff,
        44'h0_18_ffffffff, 44'h1_18_0000ffff, 44'h0_28_000000ff, 44'h1_28_0000003f, 44'h0_30_ffffffff,
        44'h0_34_ffffffff, 44'h1_38_00000001, 44'h1_3c_fffffffe, 44'h1_00_00000000};
    cwc_top DUT (.*);
    cwc_core_model u_core (.*);
    always #10 aclk = ~aclk;
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        r = s_axi_bresp;
    endtask
    task rd(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        d = s_axi_rdata;
        r = s_axi_rresp;
    endtask
    task close_out;
        if (fails == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 5000) begin
            fails++;
            close_out;
        end
    end
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(negedge aclk);
        chk({core_clk_en, dbg_enabled, irq_out, handler_active, core_halt}, 32'h18);
        foreach (rows[j]) begin
            if (rows[j][40]) rd(rows[j][39:32]);
            else wr(rows[j][39:32], rows[j][31:0]);
            chk(rows[j][40] ? d : {30'h0, r}, rows[j][40] ? rows[j][31:0] : 32'h0);
        end
        rd(8'h44);
        chk({d, r}, 32'h2);
        lat <= 8'h05;
        irq_lines <= 25'h1000080;
        @(posedge aclk);
        irq_lines <= '0;
        repeat (99) if (!handler_active) @(negedge aclk);
        chk(handler_num, 32'h7);
        repeat (99) if (!tail_chain) @(negedge aclk);
        chk(handler_num, 32'h18);
        repeat (99) if (handler_active) @(negedge aclk);
        wr(8'h04, 32'h0);
        for (k = 0; k < 4; k++) wr(8'h18 + 8'(4 * k), 32'hff);
        // Three deep sleeps, then one light sleep, each woken by a different source.
        for (k = 0; k < 4; k++) begin
            wr(8'h08, k < 3 ? 32'h3 : 32'h2);
            repeat (2) @(negedge aclk);
            chk({core_halt, core_clk_en}, k < 3 ? 32'h2 : 32'h3);
            @(posedge aclk);
            case (k)
                0: rtc_irq <= 1'b1;
                1: watch_timer_irq <= 1'b1;
                2: port_d_pins <= 8'h01;
                default: port_e_pins <= 8'h01;
            endcase
            @(posedge aclk);
            rtc_irq <= 1'b0;
            watch_timer_irq <= 1'b0;
            repeat (9) if (core_halt) @(negedge aclk);
            chk(core_halt, 32'h0);
            rd(8'h00);
            chk(d, k < 2 ? 32'h10 << k : 32'h4 << (k - 2));
            wr(8'h00, d);
        end
        wr(8'h10, 32'h4);
        wr(8'h0c, 32'h3);
        repeat (12) @(posedge aclk);
        wr(8'h0c, 32'h0);
        rd(8'h00);
        chk({d, irq_out}, 32'h4000000);
        wr(8'h04, 32'h2000000);
        repeat (20) if (!handler_active) @(negedge aclk);
        chk(handler_num, 32'h19);
        for (k = 0; k < 6; k++) begin
            @(posedge aclk);
            dbg_sel <= 3'(k);
            dbg_addr <= 32'h100 + 32'(k);
            dbg_wr <= 1'b1;
            @(posedge aclk);
            dbg_wr <= 1'b0;
            fetch_addr <= dbg_addr;
            data_addr <= dbg_addr;
            fetch_valid <= k < 4;
            data_valid <= k > 3;
            @(posedge aclk);
            fetch_valid <= 1'b0;
            data_valid <= 1'b0;
            @(negedge aclk);
            chk({break_hit, watch_hit}, k < 4 ? 32'h2 : 32'h1);
        end
        wr(8'h2c, 32'h1);
        fetch_addr <= 32'h100;
        fetch_valid <= 1'b1;
        @(posedge aclk);
        fetch_valid <= 1'b0;
        @(negedge aclk);
        chk({dbg_enabled, break_hit}, 32'h0);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(negedge aclk);
        chk(dbg_enabled, 32'h1);
        close_out;
    end
endmodule // tb_core_interrupt_wake_control
bind cwc_top cwc_chk u_chk (.*);
